// ==== fpt_flash_ctrl.sv ====
// flash pulse-width timer and two-line array read buffer with apb registers
//
// Local design decisions: register access over APB and the address map.
`default_nettype none

module fpt_flash_ctrl
   import fpt_pkg::*;
#(
   parameter logic [31:0] CTRL_BLOCK_ADDR = 32'h00FFF800
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [2:0]   shadow_clock_scaling_sel,
   input  wire logic [1:0]   shadow_pulse_exponent_sel,
   input  wire logic [6:0]   shadow_pulse_multiplier,
   input  wire logic [31:0]  shadow_array_base,
   input  wire logic         mb_req,
   input  wire logic [31:0]  mb_addr,
   input  wire logic         mb_write,
   input  wire logic         mb_prog_write,
   input  wire logic         mb_erase_interlock,
   input  wire logic         mb_seq,
   output logic              mb_ack,
   output logic [31:0]       mb_rdata,
   output logic              mb_last,
   output logic              arr_rd,
   output logic [31:0]       arr_line_addr,
   input  wire logic [fpt_pkg::LINE_BITS-1:0] arr_line,
   output logic              high_voltage_pulse
);
   import fpt_pkg::*;

   // ***************************************************************
   // control registers and pulse timer
   // ***************************************************************
   logic        load_q, load_d;
   logic        ehv_q, ehv_d, ses_q, ses_d, pe_q, pe_d;
   logic        vt_q, vt_d, pbr_q, pbr_d, sie_q, sie_d;
   logic [1:0]  wait_q, wait_d;
   logic [2:0]  sclk_q, sclk_d;
   logic [1:0]  exp_q, exp_d;
   logic [6:0]  mul_q, mul_d;
   logic [31:0] base_q, base_d;
   logic [25:0] cnt_q, cnt_d;
   logic [1:0]  pre_q, pre_d;
   logic        half_q, half_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [4:0]  n_exp;
   logic [25:0] target;
   logic [1:0]  lim;
   logic        auto_end, wr_en, setup, mapped;
   logic        inv_all, inv_lo;
   logic [1:0]  valid_q, valid_d;

   always_comb begin
      n_exp = EXP_BASE + {3'h0, exp_q} + (pe_q ? EXP_PE_STEP : 5'h00);
      target = (26'(mul_q) + 26'h1) << n_exp;
      auto_end = (sclk_q != SCLK_OFF) && (sclk_q <= SCLK_X3);
      unique case (sclk_q)
         SCLK_X1P5: lim = half_q ? 2'h1 : 2'h0;
         SCLK_X2:   lim = 2'h1;
         SCLK_X3:   lim = 2'h2;
         default:   lim = 2'h0;
      endcase
   end

   always_comb begin
      load_d = 1'b0;
      {ehv_d, ses_d, pe_d, vt_d, pbr_d, sie_d} =
         {ehv_q, ses_q, pe_q, vt_q, pbr_q, sie_q};
      wait_d = wait_q;
      sclk_d = sclk_q;
      exp_d = exp_q;
      mul_d = mul_q;
      base_d = base_q;
      cnt_d = 26'h0;
      pre_d = 2'h0;
      half_d = 1'b0;
      if (load_q) begin
         sclk_d = shadow_clock_scaling_sel;
         exp_d = shadow_pulse_exponent_sel;
         mul_d = shadow_pulse_multiplier;
         base_d = shadow_array_base & BASE_MASK;
      end
      if (ehv_q && auto_end) begin
         cnt_d = cnt_q;
         half_d = half_q;
         if (pre_q == lim) begin
            half_d = ~half_q;
            cnt_d = cnt_q + 26'h1;
            if (cnt_q + 26'h1 >= target) begin
               ehv_d = 1'b0;
            end
         end else begin
            pre_d = pre_q + 2'h1;
         end
      end
      setup = psel && !penable;
      mapped = (paddr[7:0] == OFS_CTRL) || (paddr[7:0] == OFS_TIMING) ||
               (paddr[7:0] == OFS_BASE) || (paddr[7:0] == OFS_STATUS);
      pready_d = setup && !pready_q;
      pslverr_d = setup ? (!mapped || paddr[31:8] != 24'h0) : 1'b0;
      prdata_d = prdata_q;
      if (setup) begin
         prdata_d = 32'h0;
         if (paddr[31:8] == 24'h0) begin
            unique case (paddr[7:0])
               OFS_CTRL: prdata_d = 32'({wait_q, sie_q, pbr_q, vt_q,
                                         pe_q, ses_q, ehv_q});
               OFS_TIMING: prdata_d = 32'(mul_q) << TIM_MUL_LSB |
                                      32'(exp_q) << TIM_EXP_LSB |
                                      32'(sclk_q) << TIM_SCLK_LSB;
               OFS_BASE: prdata_d = base_q;
               OFS_STATUS: prdata_d = 32'(ehv_q) << STAT_PULSE_BIT |
                                      32'(valid_q);
               default: prdata_d = 32'h0;
            endcase
         end
      end
      wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
      if (wr_en && paddr[7:0] == OFS_CTRL) begin
         ehv_d = pwdata[CTRL_EHV_BIT];
         ses_d = pwdata[CTRL_SES_BIT];
         pe_d = pwdata[CTRL_PE_BIT];
         vt_d = pwdata[CTRL_VT_BIT];
         pbr_d = pwdata[CTRL_PBR_BIT];
         sie_d = pwdata[CTRL_SIE_BIT];
         wait_d = pwdata[CTRL_WAIT_LSB +: 2];
      end
      if (wr_en && paddr[7:0] == OFS_TIMING) begin
         sclk_d = pwdata[TIM_SCLK_LSB +: 3];
         exp_d = pwdata[TIM_EXP_LSB +: 2];
         mul_d = pwdata[TIM_MUL_LSB +: 7];
      end
      if (wr_en && paddr[7:0] == OFS_BASE) begin
         base_d = pwdata & BASE_MASK;
      end
      inv_all = (ehv_d && !ehv_q) || (ses_q && !ses_d) ||
                (vt_d != vt_q) || (pbr_d != pbr_q);
      inv_lo = inv_all || (sie_d != sie_q);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         load_q <= 1'b1;
         {ehv_q, ses_q, pe_q, vt_q, pbr_q, sie_q} <= 6'h00;
         wait_q <= WAIT_RST;
         sclk_q <= SCLK_OFF;
         exp_q <= 2'h0;
         mul_q <= 7'h00;
         base_q <= 32'h0;
         cnt_q <= 26'h0;
         pre_q <= 2'h0;
         half_q <= 1'b0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         load_q <= load_d;
         {ehv_q, ses_q, pe_q, vt_q, pbr_q, sie_q} <=
            {ehv_d, ses_d, pe_d, vt_d, pbr_d, sie_d};
         wait_q <= wait_d;
         sclk_q <= sclk_d;
         exp_q <= exp_d;
         mul_q <= mul_d;
         base_q <= base_d;
         cnt_q <= cnt_d;
         pre_q <= pre_d;
         half_q <= half_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign high_voltage_pulse = ehv_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ***************************************************************
   // array read path with two line buffers
   // ***************************************************************
   fpt_rd_state_t     st_q, st_d;
   logic [1:0]        wcnt_q, wcnt_d;
   logic [11:0]       tag_q [2];
   logic [11:0]       tag_d [2];
   logic [LINE_BITS-1:0] line_q [2];
   logic [LINE_BITS-1:0] line_d [2];
   logic [31:0]       cur_q, cur_d, pend_q, pend_d, acc;
   logic              seq_ok_q, seq_ok_d, ack_q, ack_d, last_q, last_d;
   logic [31:0]       rdata_q, rdata_d, aaddr_q, aaddr_d;
   logic              ard_q, ard_d, take, half, phalf;
   logic [1:0]        hit;
   logic [7:0]        bofs, pofs;

   always_comb begin
      acc = (mb_seq && seq_ok_q) ? cur_q + 32'h4 : mb_addr;
      half = acc[HALF_BIT];
      phalf = pend_q[HALF_BIT];
      bofs = {acc[4:2], 5'h00};
      pofs = {pend_q[4:2], 5'h00};
   end

   for (genvar b = 0; b < 2; b++) begin : g_hit
      assign hit[b] = valid_q[b] && (tag_q[b] == acc[16:5]);
   end

   always_comb begin
      st_d = st_q;
      wcnt_d = wcnt_q;
      valid_d = valid_q;
      tag_d = tag_q;
      line_d = line_q;
      cur_d = cur_q;
      pend_d = pend_q;
      seq_ok_d = seq_ok_q;
      ack_d = 1'b0;
      last_d = last_q;
      rdata_d = rdata_q;
      aaddr_d = aaddr_q;
      ard_d = ard_q;
      take = mb_req && !ack_q && (st_q == RD_IDLE) &&
             (acc[31:ARRAY_AW] == base_q[31:ARRAY_AW]) &&
             (acc[31:LINE_AW] != CTRL_BLOCK_ADDR[31:LINE_AW]);
      unique case (st_q)
         RD_IDLE: begin
            if (take && mb_write) begin
               if (mb_prog_write || mb_erase_interlock) begin
                  ack_d = 1'b1;
                  last_d = 1'b1;
                  seq_ok_d = 1'b0;
                  valid_d = 2'h0;
               end
            end else if (take && hit[half]) begin
               ack_d = 1'b1;
               rdata_d = line_q[half][bofs +: 32];
               last_d = (acc[4:2] == LAST_WORD);
               seq_ok_d = (acc[4:2] != LAST_WORD);
               cur_d = acc;
            end else if (take) begin
               valid_d[half] = 1'b0;
               ard_d = 1'b1;
               aaddr_d = {acc[31:LINE_AW], 5'h00};
               pend_d = acc;
               wcnt_d = wait_q;
               st_d = RD_FETCH;
            end
         end
         RD_FETCH: begin
            if (wcnt_q == 2'h0) begin
               line_d[phalf] = arr_line;
               tag_d[phalf] = pend_q[16:5];
               valid_d[phalf] = 1'b1;
               ard_d = 1'b0;
               ack_d = 1'b1;
               rdata_d = arr_line[pofs +: 32];
               last_d = (pend_q[4:2] == LAST_WORD);
               seq_ok_d = (pend_q[4:2] != LAST_WORD);
               cur_d = pend_q;
               st_d = RD_IDLE;
            end else begin
               wcnt_d = wcnt_q - 2'h1;
            end
         end
      endcase
      if (inv_lo) begin
         valid_d[0] = 1'b0;
      end
      if (inv_all) begin
         valid_d[1] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= RD_IDLE;
         wcnt_q <= 2'h0;
         valid_q <= 2'h0;
         tag_q <= '{default: 12'h000};
         line_q <= '{default: '0};
         cur_q <= 32'h0;
         pend_q <= 32'h0;
         seq_ok_q <= 1'b0;
         ack_q <= 1'b0;
         last_q <= 1'b0;
         rdata_q <= 32'h0;
         aaddr_q <= 32'h0;
         ard_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wcnt_q <= wcnt_d;
         valid_q <= valid_d;
         tag_q <= tag_d;
         line_q <= line_d;
         cur_q <= cur_d;
         pend_q <= pend_d;
         seq_ok_q <= seq_ok_d;
         ack_q <= ack_d;
         last_q <= last_d;
         rdata_q <= rdata_d;
         aaddr_q <= aaddr_d;
         ard_q <= ard_d;
      end
   end

   assign mb_ack = ack_q;
   assign mb_rdata = rdata_q;
   assign mb_last = last_q;
   assign arr_rd = ard_q;
   assign arr_line_addr = aaddr_q;

endmodule

`default_nettype wire

// ==== fpt_pkg.sv ====
// constants and types shared by the flash pulse timer and read buffer block
`default_nettype none

package fpt_pkg;

   // ***************************************************************
   // register offsets on the apb window
   // ***************************************************************
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_TIMING     = 8'h04;
   localparam logic [7:0]  OFS_BASE       = 8'h08;
   localparam logic [7:0]  OFS_STATUS     = 8'h0C;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int unsigned CTRL_EHV_BIT   = 0;
   localparam int unsigned CTRL_SES_BIT   = 1;
   localparam int unsigned CTRL_PE_BIT    = 2;
   localparam int unsigned CTRL_VT_BIT    = 3;
   localparam int unsigned CTRL_PBR_BIT   = 4;
   localparam int unsigned CTRL_SIE_BIT   = 5;
   localparam int unsigned CTRL_WAIT_LSB  = 6;
   localparam int unsigned TIM_SCLK_LSB   = 0;
   localparam int unsigned TIM_EXP_LSB    = 4;
   localparam int unsigned TIM_MUL_LSB    = 8;
   localparam int unsigned STAT_PULSE_BIT = 8;

   // ***************************************************************
   // reset values and timing figures
   // ***************************************************************
   localparam logic [1:0]  WAIT_RST       = 2'h0;
   localparam logic [4:0]  EXP_BASE       = 5'h05;
   localparam logic [4:0]  EXP_PE_STEP    = 5'h0A;
   localparam logic [2:0]  SCLK_OFF       = 3'h0;
   localparam logic [2:0]  SCLK_X1        = 3'h1;
   localparam logic [2:0]  SCLK_X1P5      = 3'h2;
   localparam logic [2:0]  SCLK_X2        = 3'h3;
   localparam logic [2:0]  SCLK_X3        = 3'h4;

   // ***************************************************************
   // array geometry
   // ***************************************************************
   localparam int unsigned NUM_BLOCKS     = 8;
   localparam int unsigned BLOCK_BYTES    = 32768;
   localparam int unsigned ARRAY_AW       = 18;
   localparam int unsigned HALF_BIT       = 17;
   localparam int unsigned LINE_AW        = 5;
   localparam int unsigned LINE_BITS      = 256;
   localparam logic [2:0]  LAST_WORD      = 3'h7;
   localparam logic [31:0] BASE_MASK      = 32'hFFFC0000;

   typedef enum logic [0:0] {RD_IDLE, RD_FETCH} fpt_rd_state_t;

endpackage

`default_nettype wire

// ==== fpt_flash_ctrl_monitor.sv ====
// checker on the flash controller ports, bound to its top module
`default_nettype none
module fpt_flash_ctrl_monitor
   import fpt_pkg::*;
#(
   parameter logic [31:0] CTRL_BLOCK_ADDR = 32'h00FFF800
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        mb_req,
   input wire logic [31:0] mb_addr,
   input wire logic        mb_write,
   input wire logic        mb_prog_write,
   input wire logic        mb_erase_interlock,
   input wire logic        mb_ack,
   input wire logic        arr_rd,
   input wire logic [31:0] arr_line_addr,
   input wire logic        high_voltage_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire ctl_wr = psel && penable && pready && pwrite
                 && paddr == 32'(OFS_CTRL);
   chk_ack_pulse: assert property (mb_ack |=> !mb_ack)
      else $error("module bus ack longer than one cycle");
   chk_fetch_len: assert property (
      $rose(arr_rd) |-> ##[1:4] (mb_ack && !arr_rd))
      else $error("line fetch did not complete in time");
   chk_line_align: assert property (
      arr_rd |-> arr_line_addr[4:0] == 5'h00)
      else $error("fetch address not line aligned");
   chk_plain_write: assert property (
      mb_req && mb_write && !mb_prog_write && !mb_erase_interlock
      |-> !mb_ack)
      else $error("plain array write acknowledged");
   chk_ctrl_hole: assert property (
      mb_req && mb_addr[31:5] == CTRL_BLOCK_ADDR[31:5] |=> !mb_ack)
      else $error("array access on control block acknowledged");
   chk_pulse_stop: assert property (
      ctl_wr && !pwdata[0] |=> !high_voltage_pulse)
      else $error("pulse still applied after enable cleared");
   chk_pulse_start: assert property (
      ctl_wr && pwdata[0] |=> high_voltage_pulse)
      else $error("pulse not applied after enable set");
   chk_ack_idle: assert property (mb_ack |-> !arr_rd)
      else $error("fetch still running at completion");
endmodule

bind fpt_flash_ctrl fpt_flash_ctrl_monitor #(
   .CTRL_BLOCK_ADDR(CTRL_BLOCK_ADDR)
) fpt_flash_ctrl_monitor_inst (
   .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .mb_req, .mb_addr, .mb_write, .mb_prog_write, .mb_erase_interlock,
   .mb_ack, .arr_rd, .arr_line_addr, .high_voltage_pulse
);
`default_nettype wire

// ==== fpt_array_model.sv ====
// flash array model answering line fetches with an address pattern
`default_nettype none
module fpt_array_model
   import fpt_pkg::*;
(
   input wire logic                      arr_rd,
   input wire logic [31:0]               arr_line_addr,
   output logic [fpt_pkg::LINE_BITS-1:0] arr_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle array shows the inverse pattern, never a stale line
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         arr_line[32*k +: 32] = (arr_line_addr + 32'(4 * k))
                                ^ 32'h5A5AC3C3 ^ {32{!arr_rd}};
      end
   end
endmodule
`default_nettype wire

// ==== fpt_flash_ctrl_tb.sv ====
// self-checking bench for the pulse timer and read buffers
`default_nettype none
module fpt_flash_ctrl_tb;
   import fpt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] BASE = 32'h00FC0000;
   localparam logic [31:0] PAT  = 32'h5A5AC3C3;
   logic        clk, pready, pslverr, mb_ack, mb_last, arr_rd, hv, serr;
   logic        nrst = 0, psel = 0, penable = 0, pwrite = 0, mb_req = 0;
   logic        mb_write = 0, mb_prog_write = 0, mb_erase_interlock = 0;
   logic        mb_seq = 0;
   logic [31:0] paddr = 0, pwdata = 0, mb_addr = 0;
   logic [31:0] prdata, mb_rdata, arr_line_addr, rd;
   logic [LINE_BITS-1:0] arr_line;
   int          fails = 0, n_checks = 0, cyc = 0, n;
   int          rx2[4] = '{2, 3, 4, 6};
   logic [31:0] hold[4] = '{32'h300, 32'h305, 32'h306, 32'h307};
   logic [31:0] inv[7] = '{32'h8A, 32'h82, 32'h92, 32'h82, 32'hA2, 32'h82,
                           32'h80};
   fpt_flash_ctrl fpt_flash_ctrl_inst (
      .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .shadow_clock_scaling_sel(3'h1),
      .shadow_pulse_exponent_sel(2'h0), .shadow_pulse_multiplier(7'h03),
      .shadow_array_base(32'h00FC0123), .mb_req, .mb_addr, .mb_write,
      .mb_prog_write, .mb_erase_interlock, .mb_seq, .mb_ack, .mb_rdata,
      .mb_last, .arr_rd, .arr_line_addr, .arr_line,
      .high_voltage_pulse(hv));
   fpt_array_model fpt_array_model_inst (.arr_rd, .arr_line_addr, .arr_line);
   // ****************************************
   // clock, timeout and checking tasks
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         $display("FAIL timeout expected end seen %0d cycles", cyc);
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // wpe is write, program, erase; 39 clocks means never answered
   task automatic mb(input logic [31:0] a, input logic [2:0] wpe,
                     input logic sq, input int clocks, input logic last);
      @(posedge clk);
      mb_req <= 1'b1;
      mb_addr <= a;
      {mb_write, mb_prog_write, mb_erase_interlock} <= wpe;
      mb_seq <= sq;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (mb_ack !== 1'b1 && n < 40);
      mb_req <= 1'b0;
      chk("mb clocks", clocks, n - 1);
      chk("mb last", {31'h0, last}, {31'h0, mb_last});
      if (!wpe[2] && clocks < 39)
         chk("mb data", a ^ PAT, mb_rdata);
   endtask
   task automatic pulse(input logic [31:0] tim, input int len);
      apb(1'b1, 32'(OFS_TIMING), tim);
      apb(1'b1, 32'(OFS_CTRL), 32'h3);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hv === 1'b1 && n < 3000);
      n_checks++;
      if (n < len || n > len + 2) begin
         fails++;
         $display("FAIL pulse length expected %0d seen %0d", len, n - 1);
      end
      apb(1'b0, 32'(OFS_CTRL), 32'h0);
      chk("ctrl after pulse", 32'h2, rd);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, 32'(OFS_TIMING), 32'h0);
      chk("timing reset", 32'h0301, rd);
      apb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk("status reset", 32'h0, rd);
      apb(1'b0, 32'(OFS_BASE), 32'h0);
      chk("base reset", BASE, rd);
      apb(1'b1, 32'(OFS_BASE), 32'hFFFFFFFF);
      apb(1'b0, 32'(OFS_BASE), 32'h0);
      chk("base align", BASE_MASK, rd);
      apb(1'b1, 32'(OFS_BASE), BASE);
      apb(1'b0, 32'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, serr});
      apb(1'b1, 32'(OFS_CTRL), 32'h82);
      mb(BASE + 32'h40, 3'b000, 1'b0, 4, 1'b0);
      for (int k = 1; k < 8; k++)
         mb(BASE + 32'(64 + 4 * k), 3'b000, 1'b1, 1, k == 7);
      mb(BASE + 32'h20100, 3'b000, 1'b0, 4, 1'b0);
      mb(BASE + 32'h44, 3'b000, 1'b0, 1, 1'b0);
      apb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk("status both", 32'h3, rd);
      mb(32'h00FFF820, 3'b000, 1'b0, 4, 1'b0);
      mb(32'h00FFF800, 3'b000, 1'b0, 39, 1'b0);
      mb(BASE + 32'h100, 3'b100, 1'b0, 39, 1'b0);
      for (int i = 0; i < 2; i++) begin
         mb(BASE + 32'h80, i ? 3'b101 : 3'b110, 1'b0, 1, 1'b1);
         apb(1'b0, 32'(OFS_STATUS), 32'h0);
         chk("status write", 32'h0, rd);
         mb(BASE + 32'h48, 3'b000, 1'b0, 4, 1'b0);
      end
      foreach (inv[i]) begin
         mb(BASE + 32'h60, 3'b000, 1'b0, 4, 1'b0);
         apb(1'b1, 32'(OFS_CTRL), inv[i]);
         apb(1'b0, 32'(OFS_STATUS), 32'h0);
         chk("status ctrl", 32'h0, rd);
      end
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, 32'(OFS_CTRL), 32'(64 * w + 2));
         mb(BASE + 32'(256 + 32 * w), 3'b000, 1'b0, 2 + w, 1'b0);
      end
      foreach (rx2[c])
         pulse(32'(c + 1) | 32'h300, 64 * rx2[c]);
      pulse(32'h331, 1024);
      foreach (hold[i]) begin
         apb(1'b1, 32'(OFS_TIMING), hold[i]);
         apb(1'b1, 32'(OFS_CTRL), 32'h3);
         apb(1'b0, 32'(OFS_STATUS), 32'h0);
         chk("status pulse", 32'h100, rd);
         repeat (300) @(posedge clk);
         chk("pulse held", 32'h1, {31'h0, hv});
         apb(1'b1, 32'(OFS_CTRL), 32'h2);
         @(posedge clk);
         chk("pulse off", 32'h0, {31'h0, hv});
      end
      stop_test();
   end
endmodule
`default_nettype wire
